/* hdl/sdram_cmd_regs.svh */
`ifndef SDRAM_CMD_REGS_SVH
`define SDRAM_CMD_REGS_SVH
// Timing figures in nanoseconds and the clock period
`define CLK_PERIOD_NS 20
`define LAST_DATA_TO_IDLE_NS 40
`define ROW_CLOSE_NS 80
`define MODE_LOAD_SETTLE_NS 20
`define SELF_RENEW_EXIT_NS 80
`define BANK_TO_BANK_OPEN_NS 20
`define ROW_OPEN_MIN_NS 60
// Cycle counts, least times rounded up
`define CYC(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LAST_DATA_TO_IDLE_CYC `CYC(`LAST_DATA_TO_IDLE_NS)
`define ROW_CLOSE_CYC `CYC(`ROW_CLOSE_NS)
`define MODE_LOAD_SETTLE_CYC `CYC(`MODE_LOAD_SETTLE_NS)
`define SELF_RENEW_EXIT_CYC `CYC(`SELF_RENEW_EXIT_NS)
`define BANK_TO_BANK_OPEN_CYC `CYC(`BANK_TO_BANK_OPEN_NS)
`define ROW_OPEN_MIN_CYC `CYC(`ROW_OPEN_MIN_NS)
// Field positions and reset values
`define BANK_PICK_POS 9
`define OPCODE_W 10
`define OPCODE_RESET 10'h000
`define FULL_PAGE_CODE 3'h7
`endif

/* hdl/sdram_cmd_pkg.sv */
package sdram_cmd_pkg;
  // Decoded command from the strobe pins
  typedef enum logic [3:0] {
    deselect_cmd = 4'h0,
    no_operation_cmd = 4'h1,
    burst_stop_cmd = 4'h2,
    column_read_cmd = 4'h3,
    column_store_cmd = 4'h4,
    row_open_cmd = 4'h5,
    row_close_cmd = 4'h6,
    auto_rows_renew_cmd = 4'h7,
    mode_load_cmd = 4'h8
  } cmd_t;
  // Device-wide state
  typedef enum logic [2:0] {
    dev_idle = 3'b000,
    dev_refresh = 3'b001,
    dev_mode_load = 3'b010,
    dev_self_refresh = 3'b011,
    dev_self_recovery = 3'b100,
    dev_power_down = 3'b101,
    dev_active = 3'b110
  } dev_state_t;
  // Per-bank state
  typedef enum logic [1:0] {
    bank_idle = 2'b00,
    bank_open = 2'b01,
    bank_recover_ap = 2'b10
  } bank_state_t;
endpackage

/* hdl/sdram_link_if.sv */
interface sdram_link_if;
  logic clock_gate;
  logic chip_select_n;
  logic row_strobe_n;
  logic column_strobe_n;
  logic write_strobe_n;
  logic [9:0] addr;
  logic auto_precharge;
  modport controller (output clock_gate, chip_select_n, row_strobe_n, column_strobe_n,
    write_strobe_n, addr, auto_precharge);
  modport device (input clock_gate, chip_select_n, row_strobe_n, column_strobe_n,
    write_strobe_n, addr, auto_precharge);
endinterface

/* hdl/sdram_device_end.sv */
// Functional notes
// - Recovering bank ignores idle commands, idles later
// - Recovery allows other-bank commands only
// - Refresh ignores idle commands, idles after time
// - Mode load ignores idle commands, settles then
// - Commands decoded from four strobe pins
// - All inputs captured on rising clock
// - Mode load copies address into opcode
// - Refresh ignores address and data
// - Self-refresh ignores all but gate, select, row and column strobes
// - Column commands need open bank
// - Burst stop works only at full page
// - Clock gate low, banks idle: power-down
// - Self-refresh entry: gate low with refresh
// - Second activate waits bank gap
// - Precharge waits row open minimum
// - Auto-precharge closes bank after burst
// - Self-refresh exit recovers, then idles
// - Gate low in recovery: power-down next
// - Clock suspend holds while gate low
// - Gate rise, sampled on the rising clock, ends power-down
`include "sdram_cmd_regs.svh"
module sdram_device_end
  import sdram_cmd_pkg::*;
#(
  parameter int BURST_CYC = 4
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  // Link from the controller
  sdram_link_if.device link,
  // Observed state
  output dev_state_t dev_state_out,
  output logic [1:0] bank_open_out,
  output logic [`OPCODE_W-1:0] mode_opcode_out,
  output logic suspend_out,
  output logic burst_stop_taken_out,
  output logic illegal_cmd_out
);
  // ----------------------------------------------------------------
  // Input capture and decode
  // ----------------------------------------------------------------
  cmd_t cmd;
  logic [9:0] addr_q;
  logic ap_q;
  logic gate_q;
  logic cs_n_q, ras_n_q, cas_n_q, we_n_q;
  // Inputs sampled on each rising edge
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      gate_q <= 1'b1;
      cs_n_q <= 1'b1;
      ras_n_q <= 1'b1;
      cas_n_q <= 1'b1;
      we_n_q <= 1'b1;
      addr_q <= 10'h000;
      ap_q <= 1'b0;
    end else begin
      gate_q <= link.clock_gate;
      cs_n_q <= link.chip_select_n;
      ras_n_q <= link.row_strobe_n;
      cas_n_q <= link.column_strobe_n;
      we_n_q <= link.write_strobe_n;
      addr_q <= link.addr;
      ap_q <= link.auto_precharge;
    end
  end
  // Strobe decode into a command
  always_comb begin
    if (cs_n_q) begin
      cmd = deselect_cmd;
    end else begin
      case ({ras_n_q, cas_n_q, we_n_q})
        3'b111: cmd = no_operation_cmd;
        3'b110: cmd = burst_stop_cmd;
        3'b101: cmd = column_read_cmd;
        3'b100: cmd = column_store_cmd;
        3'b011: cmd = row_open_cmd;
        3'b010: cmd = row_close_cmd;
        3'b001: cmd = auto_rows_renew_cmd;
        default: cmd = mode_load_cmd;
      endcase
    end
  end
  wire bank_sel = addr_q[`BANK_PICK_POS];
  wire quiet_cmd = (cmd == deselect_cmd) || (cmd == no_operation_cmd) ||
    (cmd == burst_stop_cmd);
  wire exit_ok = cs_n_q || (ras_n_q && cas_n_q);
  wire full_page = (mode_opcode_out[2:0] == `FULL_PAGE_CODE);
  // ----------------------------------------------------------------
  // Device state
  // ----------------------------------------------------------------
  dev_state_t dev_state;
  dev_state_t next_dev_state;
  logic [7:0] wait_cnt;
  logic [7:0] next_wait_cnt;
  bank_state_t bank_st [2];
  logic [7:0] bank_cnt [2];
  wire banks_idle = (bank_st[0] == bank_idle) && (bank_st[1] == bank_idle);
  wire wait_done = (wait_cnt == 8'h00);
  // Next device state; gate low only counts with both banks idle
  always_comb begin
    next_dev_state = dev_state;
    next_wait_cnt = wait_done ? 8'h00 : wait_cnt - 8'h01;
    case (dev_state)
      dev_idle, dev_active: begin
        if (!banks_idle) begin
          next_dev_state = dev_active;
        end else if (!gate_q && cmd == auto_rows_renew_cmd) begin
          next_dev_state = dev_self_refresh;
        end else if (!gate_q) begin
          next_dev_state = dev_power_down;
        end else if (cmd == auto_rows_renew_cmd) begin
          next_dev_state = dev_refresh;
          next_wait_cnt = 8'(`ROW_CLOSE_CYC - 1);
        end else if (cmd == mode_load_cmd) begin
          next_dev_state = dev_mode_load;
          next_wait_cnt = 8'(`MODE_LOAD_SETTLE_CYC - 1);
        end else begin
          next_dev_state = dev_idle;
        end
      end
      // Quiet commands ignored until the interval ends
      dev_refresh, dev_mode_load: begin
        if (wait_done) begin
          next_dev_state = dev_idle;
        end
      end
      // Only the clock gate and the chip select, row and column strobes are looked at here
      dev_self_refresh: begin
        if (gate_q && exit_ok) begin
          next_dev_state = dev_self_recovery;
          next_wait_cnt = 8'(`SELF_RENEW_EXIT_CYC - 1);
        end
      end
      dev_self_recovery: begin
        if (!gate_q && exit_ok) begin
          next_dev_state = dev_power_down;
        end else if (wait_done) begin
          next_dev_state = dev_idle;
        end
      end
      dev_power_down: begin
        if (gate_q) begin
          next_dev_state = dev_idle;
        end
      end
      default: next_dev_state = dev_idle;
    endcase
  end
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      dev_state <= dev_idle;
      wait_cnt <= 8'h00;
    end else begin
      dev_state <= next_dev_state;
      wait_cnt <= next_wait_cnt;
    end
  end
  // ----------------------------------------------------------------
  // Per-bank state; commands act only while not suspended
  // ----------------------------------------------------------------
  wire live = gate_q && (dev_state == dev_idle || dev_state == dev_active);
  genvar b;
  generate
    for (b = 0; b < 2; b++) begin : g_bank
      wire hit = (bank_sel == 1'(b));
      always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          bank_st[b] <= bank_idle;
          bank_cnt[b] <= 8'h00;
        end else if (bank_st[b] == bank_recover_ap) begin
          // Quiet commands leave recovery running
          if (bank_cnt[b] == 8'h00) begin
            bank_st[b] <= bank_idle;
          end else begin
            bank_cnt[b] <= bank_cnt[b] - 8'h01;
          end
        end else if (live && hit) begin
          if (cmd == row_open_cmd && bank_st[b] == bank_idle) begin
            bank_st[b] <= bank_open;
          end else if (cmd == row_close_cmd) begin
            bank_st[b] <= bank_idle;
          end else if (cmd == column_store_cmd && ap_q && bank_st[b] == bank_open) begin
            bank_st[b] <= bank_recover_ap;
            bank_cnt[b] <= 8'(BURST_CYC + `LAST_DATA_TO_IDLE_CYC - 1);
          end else if (cmd == column_read_cmd && ap_q && bank_st[b] == bank_open) begin
            bank_st[b] <= bank_recover_ap;
            bank_cnt[b] <= 8'(BURST_CYC - 1);
          end
        end
      end
    end
  endgenerate
  // Commands that break the tables for the current state
  wire recov_hit = (bank_st[bank_sel] == bank_recover_ap) && !quiet_cmd &&
    (cmd != mode_load_cmd) && (cmd != auto_rows_renew_cmd);
  wire recov_any = (bank_st[0] == bank_recover_ap || bank_st[1] == bank_recover_ap) &&
    (cmd == mode_load_cmd || cmd == auto_rows_renew_cmd);
  wire busy_bad = (dev_state == dev_refresh || dev_state == dev_mode_load) && !quiet_cmd;
  wire exit_bad = (dev_state == dev_self_recovery ||
    (dev_state == dev_self_refresh && gate_q)) && !exit_ok;
  wire illegal = live && (recov_hit || recov_any) || busy_bad || exit_bad;
  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      suspend_out <= 1'b0;
      mode_opcode_out <= `OPCODE_RESET;
      burst_stop_taken_out <= 1'b0;
      illegal_cmd_out <= 1'b0;
      dev_state_out <= dev_idle;
      bank_open_out <= 2'b00;
    end else begin
      suspend_out <= !gate_q && (dev_state == dev_active);
      if (live && banks_idle && cmd == mode_load_cmd) begin
        mode_opcode_out <= addr_q;
      end
      burst_stop_taken_out <= live && !banks_idle && cmd == burst_stop_cmd &&
        full_page;
      illegal_cmd_out <= illegal;
      dev_state_out <= next_dev_state;
      bank_open_out <= {bank_st[1] != bank_idle, bank_st[0] != bank_idle};
    end
  end
endmodule

/* hdl/sdram_ctrl_end.sv */
`include "sdram_cmd_regs.svh"
module sdram_ctrl_end
  import sdram_cmd_pkg::*;
#(
  parameter int BURST_CYC = 4
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  // User request: cmd and bank, taken unless refused; ready or reject a cycle later
  input wire logic req_valid_in,
  input wire cmd_t req_cmd_in,
  input wire logic [9:0] req_addr_in,
  input wire logic req_ap_in,
  input wire logic req_gate_in,
  output logic req_ready_out,
  output logic req_reject_out,
  // Link to the device
  sdram_link_if.controller link
);
  // ----------------------------------------------------------------
  // Legality tracking
  // ----------------------------------------------------------------
  logic [1:0] open_q;
  logic [7:0] busy_cnt;
  logic [7:0] rrd_cnt;
  logic [7:0] ras_cnt [2];
  logic [7:0] recov_cnt [2];
  wire bank = req_addr_in[`BANK_PICK_POS];
  wire both_idle = (open_q == 2'b00) && recov_cnt[0] == 8'h00 && recov_cnt[1] == 8'h00;
  wire quiet = req_cmd_in == deselect_cmd || req_cmd_in == no_operation_cmd;
  wire recov = recov_cnt[bank] != 8'h00;
  // Refusal of any command that the device would not accept, of early activates and precharges, and of every burst stop
  wire bad =
    (busy_cnt != 8'h00 && !quiet) ||
    (recov && !quiet) ||
    // Gate low with a bank busy is a clock suspend, so only quiet commands may ride it
    ((req_cmd_in == mode_load_cmd || req_cmd_in == auto_rows_renew_cmd) &&
      !both_idle) ||
    (!req_gate_in && !quiet && req_cmd_in != auto_rows_renew_cmd) ||
    ((req_cmd_in == column_read_cmd || req_cmd_in == column_store_cmd) &&
      !open_q[bank]) ||
    (req_cmd_in == row_open_cmd && (open_q[bank] || rrd_cnt != 8'h00)) ||
    (req_cmd_in == row_close_cmd && ras_cnt[bank] != 8'h00) ||
    (req_cmd_in == burst_stop_cmd);
  wire take = req_valid_in && !bad;
  wire ap_col = (req_cmd_in == column_read_cmd || req_cmd_in == column_store_cmd) && req_ap_in;
  genvar b;
  generate
    for (b = 0; b < 2; b++) begin : g_bank
      wire hit = take && bank == 1'(b);
      always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          open_q[b] <= 1'b0;
          ras_cnt[b] <= 8'h00;
          recov_cnt[b] <= 8'h00;
        end else begin
          ras_cnt[b] <= (ras_cnt[b] != 8'h00) ? ras_cnt[b] - 8'h01 : 8'h00;
          recov_cnt[b] <= (recov_cnt[b] != 8'h00) ? recov_cnt[b] - 8'h01 : 8'h00;
          if (hit && req_cmd_in == row_open_cmd) begin
            open_q[b] <= 1'b1;
            ras_cnt[b] <= 8'(`ROW_OPEN_MIN_CYC);
          end else if (hit && (req_cmd_in == row_close_cmd || ap_col)) begin
            open_q[b] <= 1'b0;
            if (ap_col) begin
              recov_cnt[b] <= 8'(BURST_CYC + `LAST_DATA_TO_IDLE_CYC + 1);
            end
          end
        end
      end
    end
  endgenerate
  // Shared counters and pin drive, all outputs from flops
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      busy_cnt <= 8'h00;
      rrd_cnt <= 8'h00;
      req_ready_out <= 1'b0;
      req_reject_out <= 1'b0;
      link.clock_gate <= 1'b1;
      link.chip_select_n <= 1'b1;
      link.row_strobe_n <= 1'b1;
      link.column_strobe_n <= 1'b1;
      link.write_strobe_n <= 1'b1;
      link.addr <= 10'h000;
      link.auto_precharge <= 1'b0;
    end else begin
      busy_cnt <= (busy_cnt != 8'h00) ? busy_cnt - 8'h01 : 8'h00;
      rrd_cnt <= (rrd_cnt != 8'h00) ? rrd_cnt - 8'h01 : 8'h00;
      req_ready_out <= take;
      req_reject_out <= req_valid_in && bad;
      link.clock_gate <= take ? req_gate_in : 1'b1;
      link.chip_select_n <= !(take && !quiet);
      link.row_strobe_n <= !(take && req_cmd_in inside {row_open_cmd, row_close_cmd,
        auto_rows_renew_cmd, mode_load_cmd});
      link.column_strobe_n <= !(take && req_cmd_in inside {column_read_cmd,
        column_store_cmd, auto_rows_renew_cmd, mode_load_cmd});
      link.write_strobe_n <= !(take && req_cmd_in inside {burst_stop_cmd, column_store_cmd,
        row_close_cmd, mode_load_cmd});
      link.addr <= req_addr_in;
      link.auto_precharge <= req_ap_in;
      if (take && req_cmd_in == auto_rows_renew_cmd && req_gate_in) begin
        busy_cnt <= 8'(`ROW_CLOSE_CYC + 1);
      end else if (take && req_cmd_in == mode_load_cmd) begin
        busy_cnt <= 8'(`MODE_LOAD_SETTLE_CYC + 1);
      end else if (take && !req_gate_in && both_idle) begin
        busy_cnt <= 8'(`SELF_RENEW_EXIT_CYC + 2);
      end
      if (take && req_cmd_in == row_open_cmd) begin
        rrd_cnt <= 8'(`BANK_TO_BANK_OPEN_CYC);
      end
    end
  end
endmodule

/* testbench/sdram_cmd_state_legality_props.sv */
module sdram_cmd_state_legality_props
  import sdram_cmd_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  // Link signals
  input wire logic clock_gate,
  input wire logic chip_select_n,
  input wire logic row_strobe_n,
  input wire logic column_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [9:0] addr,
  // Device outputs
  input wire dev_state_t dev_state_out,
  input wire logic [1:0] bank_open_out,
  input wire logic [9:0] mode_opcode_out,
  input wire logic suspend_out,
  input wire logic burst_stop_taken_out,
  input wire logic illegal_cmd_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Decoded link command
  // ----------------------------------------
  // Strobe pattern on the wire, chip select first
  wire [3:0] pins = {chip_select_n, row_strobe_n, column_strobe_n, write_strobe_n};
  wire is_mrs = pins == 4'h0;
  wire is_ref = pins == 4'h1;
  wire is_act = pins == 4'h3;
  wire idle = dev_state_out == dev_idle;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);

  // ----------------------------------------
  // Checks: device state and opcode act two edges after the pins show a command, bank flags three
  // ----------------------------------------
  mode_copy_a: assert property (
    is_mrs && clock_gate && idle |-> ##2 mode_opcode_out == $past(addr, 2))
    else $error("opcode not copied from address");
  mode_settle_a: assert property (
    is_mrs && clock_gate && idle |-> ##2 dev_state_out == dev_mode_load ##[1:3] idle)
    else $error("mode load did not settle");
  refresh_idle_a: assert property (
    is_ref && clock_gate && $past(clock_gate) && idle
    |-> ##2 dev_state_out == dev_refresh ##[2:6] idle)
    else $error("refresh did not return to idle");
  // Bank flags come from the bank state flops, one edge later than the device state
  bank_open_a: assert property (
    is_act && clock_gate && $past(clock_gate)
    |-> ##3 bank_open_out[$past(addr[9], 3)])
    else $error("activated bank not open");
  self_enter_a: assert property (
    is_ref && !clock_gate && $past(clock_gate) && idle
    |-> ##[1:3] dev_state_out == dev_self_refresh)
    else $error("self-refresh not entered");
  power_down_a: assert property (
    (chip_select_n || pins == 4'h7) && !clock_gate && $past(clock_gate) && idle
    |-> ##[1:3] dev_state_out == dev_power_down)
    else $error("power-down not entered");
  gate_wake_a: assert property (
    dev_state_out == dev_power_down && clock_gate
    |-> ##[1:3] dev_state_out != dev_power_down)
    else $error("power-down not left on gate rise");
  no_illegal_a: assert property (!illegal_cmd_out)
    else $error("controller issued an illegal command");
  no_bst_a: assert property (pins != 4'h6 && !burst_stop_taken_out)
    else $error("burst stop reached the link");

  // Main scenarios reached
  cover property (dev_state_out == dev_self_recovery);
  cover property (suspend_out);
  cover property (is_ref && clock_gate ##2 dev_state_out == dev_refresh);
endmodule

/* testbench/sdram_cmd_state_legality_tb_top.sv */
module sdram_cmd_state_legality_tb_top;
  import sdram_cmd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic clk_sys_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic v = 1'b0;
  logic ap = 1'b0;
  logic g = 1'b1;
  cmd_t c = deselect_cmd;
  logic [9:0] a = 10'h000;
  logic rdy, rej, su, bs, il, il2;
  dev_state_t st;
  logic [1:0] bo;
  logic [9:0] op;
  logic [7:0] seen = 8'h00;
  logic seen_s = 1'b0;
  logic seen_i = 1'b0;
  int bad_count = 0;
  int check_count = 0;
  sdram_link_if link ();
  sdram_link_if link2 ();
  wire [4:0] pins = {link.clock_gate, link.chip_select_n, link.row_strobe_n,
    link.column_strobe_n, link.write_strobe_n};

  sdram_ctrl_end sdram_ctrl_end_i (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
    .req_valid_in(v), .req_cmd_in(c), .req_addr_in(a), .req_ap_in(ap), .req_gate_in(g),
    .req_ready_out(rdy), .req_reject_out(rej), .link(link.controller));
  sdram_device_end sdram_device_end_i (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
    .link(link.device), .dev_state_out(st), .bank_open_out(bo), .mode_opcode_out(op),
    .suspend_out(su), .burst_stop_taken_out(bs), .illegal_cmd_out(il));
  // Second device driven straight by the bench, to break the rules on purpose
  sdram_device_end sdram_device_end_i2 (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
    .link(link2.device), .dev_state_out(), .bank_open_out(), .mode_opcode_out(),
    .suspend_out(), .burst_stop_taken_out(), .illegal_cmd_out(il2));
  sdram_cmd_state_legality_props sdram_cmd_state_legality_props_i (.clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in), .clock_gate(link.clock_gate), .chip_select_n(link.chip_select_n),
    .row_strobe_n(link.row_strobe_n), .column_strobe_n(link.column_strobe_n),
    .write_strobe_n(link.write_strobe_n), .addr(link.addr), .dev_state_out(st),
    .bank_open_out(bo), .mode_opcode_out(op), .suspend_out(su),
    .burst_stop_taken_out(bs), .illegal_cmd_out(il));

  // Clock at 50 MHz
  initial begin
    forever #10 clk_sys_in = ~clk_sys_in;
  end

  // Latch one-cycle states and pulses so scenarios cannot miss them
  always @(posedge clk_sys_in) begin
    seen[st] <= 1'b1;
    if (su) seen_s <= 1'b1;
    if (il2) seen_i <= 1'b1;
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask

  task automatic put2(input logic [3:0] p);
    {link2.chip_select_n, link2.row_strobe_n, link2.column_strobe_n, link2.write_strobe_n} = p;
  endtask

  // Raise one request, judge the answer and the wire one cycle later
  task automatic req(input cmd_t k, input logic [9:0] ad, input logic p, input logic gt,
    input logic ok);
    @(negedge clk_sys_in);
    v = 1'b1;
    c = k;
    a = ad;
    ap = p;
    g = gt;
    @(negedge clk_sys_in);
    v = 1'b0;
    chk("ready", rdy, ok);
    chk("reject", rej, !ok);
    // Quiet requests go out as a deselect with every strobe high
    if (ok) chk("pins", pins, (k inside {deselect_cmd, no_operation_cmd}) ?
      {gt, 4'hf} : {gt, 1'b0, 3'(4'h8 - k)});
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_mode();
    seen = 8'h00;
    req(mode_load_cmd, 10'h2a7, 1'b0, 1'b1, 1'b1);
    wt(6);
    chk("opcode", op, 10'h2a7);
    chk("mode state", seen[dev_mode_load], 1'b1);
    chk("mode idle", st, dev_idle);
    $display("test mode done");
  endtask

  // Address is junk on purpose: the opcode must not move
  task automatic t_refresh();
    seen = 8'h00;
    req(auto_rows_renew_cmd, 10'h155, 1'b0, 1'b1, 1'b1);
    req(row_open_cmd, 10'h000, 1'b0, 1'b1, 1'b0);
    wt(8);
    chk("refresh state", seen[dev_refresh], 1'b1);
    chk("opcode kept", op, 10'h2a7);
    chk("refresh idle", st, dev_idle);
    $display("test refresh done");
  endtask

  task automatic t_banks();
    req(row_open_cmd, 10'h000, 1'b0, 1'b1, 1'b1);
    req(row_close_cmd, 10'h000, 1'b0, 1'b1, 1'b0);
    req(column_read_cmd, 10'h200, 1'b0, 1'b1, 1'b0);
    req(burst_stop_cmd, 10'h000, 1'b0, 1'b1, 1'b0);
    req(no_operation_cmd, 10'h000, 1'b0, 1'b0, 1'b1);
    wt(4);
    chk("suspend", seen_s, 1'b1);
    chk("bank0 open", bo, 2'b01);
    req(row_close_cmd, 10'h000, 1'b0, 1'b1, 1'b1);
    wt(4);
    chk("closed", bo, 2'b00);
    $display("test banks done");
  endtask

  task automatic t_autoclose();
    req(row_open_cmd, 10'h200, 1'b0, 1'b1, 1'b1);
    wt(3);
    req(column_store_cmd, 10'h200, 1'b1, 1'b1, 1'b1);
    req(column_read_cmd, 10'h200, 1'b0, 1'b1, 1'b0);
    req(row_open_cmd, 10'h000, 1'b0, 1'b1, 1'b1);
    wt(12);
    chk("bank1 closed", bo, 2'b01);
    req(row_close_cmd, 10'h000, 1'b0, 1'b1, 1'b1);
    wt(4);
    $display("test autoclose done");
  endtask

  // The controller raises the gate after one cycle, so recovery follows at once
  task automatic t_self();
    seen = 8'h00;
    req(auto_rows_renew_cmd, 10'h000, 1'b0, 1'b0, 1'b1);
    req(row_open_cmd, 10'h000, 1'b0, 1'b1, 1'b0);
    wt(8);
    chk("self state", seen[dev_self_refresh], 1'b1);
    chk("recovery", seen[dev_self_recovery], 1'b1);
    chk("self idle", st, dev_idle);
    seen = 8'h00;
    req(no_operation_cmd, 10'h000, 1'b0, 1'b0, 1'b1);
    wt(4);
    chk("power down", seen[dev_power_down], 1'b1);
    chk("woken", st, dev_idle);
    $display("test self done");
  endtask

  task automatic t_fault();
    @(negedge clk_sys_in);
    put2(4'h1);
    @(negedge clk_sys_in);
    put2(4'h5);
    @(negedge clk_sys_in);
    put2(4'hf);
    wt(3);
    chk("illegal flagged", seen_i, 1'b1);
    $display("test fault done");
  endtask
  // ----------------------------------------
  // Sequence and verdict
  // ----------------------------------------
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    put2(4'hf);
    link2.clock_gate = 1'b1;
    link2.addr = 10'h000;
    link2.auto_precharge = 1'b0;
    repeat (12) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    reset_n_in = 1'b1;
    chk("link idle", pins, 5'h1f);
    t_mode();
    t_refresh();
    t_banks();
    t_autoclose();
    t_self();
    t_fault();
    finish_test();
  end

  // Tests need about a hundred cycles; this margin only cuts a hang
  initial begin
    #40us;
    bad_count++;
    finish_test();
  end
endmodule
